// >>> clx_classifier.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Operation
// - DMAC contribution enabled: low 12 DMAC bits feed the code.
// - SMAC contribution enabled: low 12 SMAC bits feed the code.
// - flow label contribution enabled on IPv6: all 20 bits feed the code.
// - IPv4 contribution enabled: low 8 bits of SIP and DIP feed the code.
// - L4 contribution enabled: low 8 bits of both ports, IPv4 and IPv6.
// - random mode: code comes from pseudo-random number, no header fields.
// - enabled contributions XOR into one 4-bit code, 0 to 15.
// - per-frame code is presented to the analyzer.
// - unless the frame is discarded, all CPU forwarding events OR into the final queue mask.
// - any redirect clears every front port from forwarding.
// - copy-only frames keep their normal front-port forwarding.
// - bridge reserved and all-bridges addresses: per-port redirect, copy or discard.
// - GARP address range: per-port, per-address redirect, copy or discard.
// - CCM and link-trace range: per-port, per-address redirect, copy or discard.
// - enabled: IPv4 multicast-MAC IGMP frames are redirected.
// - enabled: IPv6 multicast hop-by-hop router-alert frames are redirected.
// - enabled: non-IGMP IPv4 multicast to 224.0.0.x is copied.
// - source-port copy enabled: every frame from that port that is not discarded is copied.
// - VLAN check: untagged when unaware, single matching tag when aware.
// - register-access frame needs EtherType 0x8880 and identifier 0x0004.
// - four header bytes match pattern except don't-care bits.
// - on enabled port, all checks passing redirects to its queue.
// - MAC control, pause and errored frames dropped by default.
module clx_classifier
	import clx_pkg::*;
#(
	parameter int NUM_PORTS = 10
)(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  frm_valid,
	input  wire logic [3:0]            frm_port,
	input  wire logic [47:0]           frm_dmac,
	input  wire logic [47:0]           frm_smac,
	input  wire logic                  frm_is_ipv4,
	input  wire logic                  frm_is_ipv6,
	input  wire logic [7:0]            frm_ip_proto,
	input  wire logic [31:0]           frm_sip,
	input  wire logic [31:0]           frm_dip,
	input  wire logic [19:0]           frm_flow_label,
	input  wire logic                  frm_l4_valid,
	input  wire logic [15:0]           frm_sport,
	input  wire logic [15:0]           frm_dport,
	input  wire logic [7:0]            frm_opt_type,
	input  wire logic [7:0]            frm_opt_len,
	input  wire logic [15:0]           frm_opt_data,
	input  wire logic [1:0]            frm_tag_count,
	input  wire logic [11:0]           frm_vid,
	input  wire logic [15:0]           frm_etype,
	input  wire logic [47:0]           frm_payload,
	input  wire logic                  frm_mac_ctrl,
	input  wire logic                  frm_pause,
	input  wire logic                  frm_mac_err,
	input  wire logic [NUM_PORTS-1:0]  frm_fwd_mask,
	input  wire logic [NUM_QUEUES-1:0] frm_cpu_mask,
	output logic                       res_valid,
	output logic      [3:0]            res_lag_code,
	output logic      [NUM_QUEUES-1:0] res_cpu_mask,
	output logic      [NUM_PORTS-1:0]  res_fwd_mask,
	output logic                       res_discard
);
	logic [31:0] lag_cfg_ff, qsel_cfg_ff, resv_q_cfg_ff, vlan_cfg_ff, hdr_pat_ff, hdr_dc_ff;
	logic [31:0] type_cfg_ff   [NUM_PORTS];
	logic [31:0] bridge_cfg_ff [NUM_PORTS];
	logic [31:0] garp_cfg_ff   [NUM_PORTS];
	logic [31:0] ccm_cfg_ff    [NUM_PORTS];
	logic [15:0] frame_cnt_ff, redir_cnt_ff;
	logic [7:0]  last_ff;

	logic        setup, access_wr, port_hit, reg_ok;
	logic [3:0]  reg_port;
	logic [1:0]  reg_word;
	logic [31:0] nxt_rdata;

	logic [3:0]           lag_code;
	logic [31:0]          cur_type;
	clx_action_type       resv_act;
	logic [QW-1:0]        resv_q;
	logic                 port_ok, igmp_hit, mld_hit, ipmc_hit, src_hit, vlan_ok, ra_hit, drop_hit;
	logic                 ip4_mc, redirect, copy, discard;
	logic [NUM_QUEUES-1:0] nxt_cpu_mask;
	logic [NUM_PORTS-1:0]  nxt_fwd_mask;

	// ---------------- APB slave: no wait states, data staged at setup
	assign setup     = psel && !penable;
	assign access_wr = psel && penable && pwrite && pready;
	assign port_hit  = (paddr[11:8] == PORT_REGION) && (paddr[7:4] < NUM_PORTS);
	assign reg_port  = paddr[7:4];
	assign reg_word  = paddr[3:2];

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		reg_ok    = 1'b1;
		if (port_hit) begin
			case (reg_word)
				PW_TYPE:   nxt_rdata = type_cfg_ff[reg_port];
				PW_BRIDGE: nxt_rdata = bridge_cfg_ff[reg_port];
				PW_GARP:   nxt_rdata = garp_cfg_ff[reg_port];
				default:   nxt_rdata = ccm_cfg_ff[reg_port];
			endcase
		end else begin
			case (paddr)
				ADDR_LAG_CFG:    nxt_rdata = lag_cfg_ff;
				ADDR_QSEL_CFG:   nxt_rdata = qsel_cfg_ff;
				ADDR_RESV_Q_CFG: nxt_rdata = resv_q_cfg_ff;
				ADDR_VLAN_CFG:   nxt_rdata = vlan_cfg_ff;
				ADDR_HDR_PAT:    nxt_rdata = hdr_pat_ff;
				ADDR_HDR_DC:     nxt_rdata = hdr_dc_ff;
				ADDR_STATUS:     nxt_rdata = {redir_cnt_ff, frame_cnt_ff};
				ADDR_LAST:       nxt_rdata = {24'h00_0000, last_ff};
				default:         reg_ok    = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !reg_ok;
			if (setup && !pwrite) begin
				prdata <= nxt_rdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lag_cfg_ff    <= LAG_CFG_RST;
			qsel_cfg_ff   <= QSEL_RST;
			resv_q_cfg_ff <= RESV_Q_RST;
			vlan_cfg_ff   <= VLAN_RST;
			hdr_pat_ff    <= HDR_PAT_RST;
			hdr_dc_ff     <= HDR_DC_RST;
		end else if (access_wr && !port_hit) begin
			case (paddr)
				ADDR_LAG_CFG:    lag_cfg_ff    <= pwdata;
				ADDR_QSEL_CFG:   qsel_cfg_ff   <= pwdata;
				ADDR_RESV_Q_CFG: resv_q_cfg_ff <= pwdata;
				ADDR_VLAN_CFG:   vlan_cfg_ff   <= pwdata;
				ADDR_HDR_PAT:    hdr_pat_ff    <= pwdata;
				ADDR_HDR_DC:     hdr_dc_ff     <= pwdata;
				default:         lag_cfg_ff    <= lag_cfg_ff;
			endcase
		end
	end

	// per-port configuration words
	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					type_cfg_ff[p]   <= TYPE_RST;
					bridge_cfg_ff[p] <= ADDR_CFG_RST;
					garp_cfg_ff[p]   <= ADDR_CFG_RST;
					ccm_cfg_ff[p]    <= ADDR_CFG_RST;
				end else if (access_wr && port_hit && (reg_port == 4'(p))) begin
					case (reg_word)
						PW_TYPE:   type_cfg_ff[p]   <= pwdata;
						PW_BRIDGE: bridge_cfg_ff[p] <= pwdata;
						PW_GARP:   garp_cfg_ff[p]   <= pwdata;
						default:   ccm_cfg_ff[p]    <= pwdata;
					endcase
				end
			end
		end
	endgenerate

	// ---------------- aggregation code
	clx_lag_code u_lag (
		.pclk       (pclk),
		.presetn    (presetn),
		.cfg        (lag_cfg_ff),
		.dmac       (frm_dmac),
		.smac       (frm_smac),
		.is_ipv4    (frm_is_ipv4),
		.is_ipv6    (frm_is_ipv6),
		.flow_label (frm_flow_label),
		.sip        (frm_sip),
		.dip        (frm_dip),
		.l4_valid   (frm_l4_valid),
		.sport      (frm_sport),
		.dport      (frm_dport),
		.code       (lag_code),
		.rand_nib   ()
	);

	// ---------------- CPU forwarding determination
	assign port_ok  = (frm_port < NUM_PORTS);
	assign cur_type = port_ok ? type_cfg_ff[frm_port] : 32'h0000_0000;

	clx_resv_lookup u_resv (
		.dmac       (frm_dmac),
		.bridge_cfg (port_ok ? bridge_cfg_ff[frm_port] : ADDR_CFG_RST),
		.allbr_cfg  (cur_type[TYP_ALLBR +: 2]),
		.garp_cfg   (port_ok ? garp_cfg_ff[frm_port] : ADDR_CFG_RST),
		.ccm_cfg    (port_ok ? ccm_cfg_ff[frm_port] : ADDR_CFG_RST),
		.resv_q_cfg (resv_q_cfg_ff),
		.action     (resv_act),
		.queue      (resv_q)
	);

	assign ip4_mc   = (frm_dmac[47:23] == IP4_MC_PREFIX) && frm_is_ipv4;
	assign igmp_hit = cur_type[TYP_IGMP] && ip4_mc && (frm_ip_proto == IGMP_PROTO);
	assign mld_hit  = cur_type[TYP_MLD] && (frm_dmac[47:32] == IP6_MC_PREFIX) && frm_is_ipv6 &&
		(frm_ip_proto == HBH_NEXT_HDR) && (frm_opt_type == RA_OPT_TYPE) &&
		(frm_opt_len == RA_OPT_LEN) && (frm_opt_data == RA_OPT_DATA);
	assign ipmc_hit = cur_type[TYP_IPMC] && ip4_mc && (frm_ip_proto != IGMP_PROTO) &&
		(frm_dip[31:8] == IP4_LOCAL_NET);
	assign src_hit  = cur_type[TYP_SRCPORT];
	// double-tagged frames never qualify
	assign vlan_ok  = vlan_cfg_ff[VL_AWARE] ?
		((frm_tag_count == 2'd1) && (frm_vid == vlan_cfg_ff[VL_VID +: 12])) :
		(frm_tag_count == 2'd0);
	assign ra_hit   = cur_type[TYP_REGACC] && vlan_ok && (frm_etype == REGACC_ETYPE) &&
		(frm_payload[47:32] == REGACC_PID) &&
		(((frm_payload[31:0] ^ hdr_pat_ff) & ~hdr_dc_ff) == 32'h0000_0000);
	assign drop_hit = cur_type[TYP_DROP] && (frm_mac_ctrl || frm_pause || frm_mac_err);

	assign redirect = (resv_act == ACT_REDIRECT) || igmp_hit || mld_hit || ra_hit;
	assign copy     = (resv_act == ACT_COPY) || ipmc_hit || src_hit;
	assign discard  = drop_hit || (resv_act == ACT_DISCARD);

	always_comb begin
		nxt_cpu_mask = frm_cpu_mask;
		if (!discard) begin
			if ((resv_act == ACT_REDIRECT) || (resv_act == ACT_COPY)) begin
				nxt_cpu_mask[resv_q] = 1'b1;
			end
			if (igmp_hit) begin
				nxt_cpu_mask[qsel_cfg_ff[QS_IGMP +: QW]] = 1'b1;
			end
			if (mld_hit) begin
				nxt_cpu_mask[qsel_cfg_ff[QS_MLD +: QW]] = 1'b1;
			end
			if (ipmc_hit) begin
				nxt_cpu_mask[qsel_cfg_ff[QS_IPMC +: QW]] = 1'b1;
			end
			if (src_hit) begin
				nxt_cpu_mask[qsel_cfg_ff[QS_SRCPORT +: QW]] = 1'b1;
			end
			if (ra_hit) begin
				nxt_cpu_mask[qsel_cfg_ff[QS_REGACC +: QW]] = 1'b1;
			end
		end
	end

	// redirect strips front ports; copy leaves them alone
	assign nxt_fwd_mask = (discard || redirect) ? '0 : frm_fwd_mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid    <= 1'b0;
			res_lag_code <= 4'h0;
			res_cpu_mask <= '0;
			res_fwd_mask <= '0;
			res_discard  <= 1'b0;
		end else begin
			res_valid <= frm_valid;
			if (frm_valid) begin
				res_lag_code <= lag_code;
				res_cpu_mask <= nxt_cpu_mask;
				res_fwd_mask <= nxt_fwd_mask;
				res_discard  <= discard;
			end
		end
	end

	// status counters and last decision
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt_ff <= 16'h0000;
			redir_cnt_ff <= 16'h0000;
			last_ff      <= 8'h00;
		end else if (frm_valid) begin
			frame_cnt_ff <= frame_cnt_ff + 16'h0001;
			redir_cnt_ff <= redir_cnt_ff + {15'h0000, (redirect && !discard)};
			last_ff      <= {1'b0, discard, redirect, copy, lag_code};
		end
	end

	// ---------------- checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_redirect_clears;
		frm_valid && redirect |=> res_valid && (res_fwd_mask == '0);
	endproperty
	a_redirect_clears: assert property (p_redirect_clears) else $error("redirect kept front ports");

	property p_copy_keeps;
		frm_valid && !redirect && !discard |=> res_fwd_mask == $past(frm_fwd_mask);
	endproperty
	a_copy_keeps: assert property (p_copy_keeps) else $error("copy altered forwarding");

	property p_or_events;
		frm_valid |=> (res_cpu_mask & $past(frm_cpu_mask)) == $past(frm_cpu_mask);
	endproperty
	a_or_events: assert property (p_or_events) else $error("external cpu event lost");

	property p_srcport_copy;
		frm_valid && src_hit && !discard |=> res_cpu_mask[$past(qsel_cfg_ff[QS_SRCPORT +: QW])];
	endproperty
	a_srcport_copy: assert property (p_srcport_copy) else $error("source port copy missing");

	property p_regacc_queue;
		frm_valid && ra_hit && !discard |=> res_cpu_mask[$past(qsel_cfg_ff[QS_REGACC +: QW])] &&
			(res_fwd_mask == '0);
	endproperty
	a_regacc_queue: assert property (p_regacc_queue) else $error("register access frame not redirected");

	property p_double_tag;
		frm_tag_count == 2'd2 |-> !ra_hit;
	endproperty
	a_double_tag: assert property (p_double_tag) else $error("double tagged frame passed vlan check");

	property p_drop_err;
		frm_valid && frm_mac_err && cur_type[TYP_DROP] |=> res_discard && (res_fwd_mask == '0);
	endproperty
	a_drop_err: assert property (p_drop_err) else $error("errored frame not dropped");

	property p_random_code;
		frm_valid && lag_cfg_ff[LAG_RAND] |=> res_lag_code == $past(u_lag.rand_nib);
	endproperty
	a_random_code: assert property (p_random_code) else $error("random code not from generator");

	property p_dmac_only;
		frm_valid && (lag_cfg_ff[5:0] == 6'h01) |=>
			res_lag_code == ($past(frm_dmac[11:8]) ^ $past(frm_dmac[7:4]) ^ $past(frm_dmac[3:0]));
	endproperty
	a_dmac_only: assert property (p_dmac_only) else $error("dmac fold wrong");

	property p_igmp_redirect;
		frm_valid && igmp_hit && !discard |=> res_cpu_mask[$past(qsel_cfg_ff[QS_IGMP +: QW])] &&
			(res_fwd_mask == '0);
	endproperty
	a_igmp_redirect: assert property (p_igmp_redirect) else $error("igmp not redirected");

	c_redirect: cover property (frm_valid && redirect && !discard);
	c_copy:     cover property (frm_valid && copy && !redirect);
	c_regacc:   cover property (frm_valid && ra_hit);
	c_discard:  cover property (frm_valid && (resv_act == ACT_DISCARD));

endmodule : clx_classifier

// >>> clx_far_model.sv
`timescale 1ns/1ps
module clx_far_model
	import clx_pkg::*;
#(
	parameter int NUM_PORTS = 10
)(
	input  wire logic                  pclk,
	input  wire logic                  res_valid,
	input  wire logic [3:0]            res_lag_code,
	input  wire logic [NUM_QUEUES-1:0] res_cpu_mask,
	input  wire logic [NUM_PORTS-1:0]  res_fwd_mask,
	input  wire logic                  res_discard,
	output logic      [3:0]            got_code,
	output logic      [NUM_QUEUES-1:0] got_cpu,
	output logic      [NUM_PORTS-1:0]  got_fwd,
	output logic                       got_disc
);
	// takes each result only in its valid cycle
	always_ff @(posedge pclk) begin
		if (res_valid) begin
			got_code <= res_lag_code;
			got_cpu <= res_cpu_mask;
			got_fwd <= res_fwd_mask;
			got_disc <= res_discard;
		end
	end
endmodule : clx_far_model

// >>> clx_lag_code.sv
`timescale 1ns/1ps
module clx_lag_code
	import clx_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] cfg,
	input  wire logic [47:0] dmac,
	input  wire logic [47:0] smac,
	input  wire logic        is_ipv4,
	input  wire logic        is_ipv6,
	input  wire logic [19:0] flow_label,
	input  wire logic [31:0] sip,
	input  wire logic [31:0] dip,
	input  wire logic        l4_valid,
	input  wire logic [15:0] sport,
	input  wire logic [15:0] dport,
	output logic      [3:0]  code,
	output logic      [3:0]  rand_nib
);
	logic [15:0] lfsr_ff;
	logic [3:0]  c_dmac, c_smac, c_flow, c_ip4, c_l4;

	// free-running source for random codes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_ff <= LFSR_SEED;
		end else begin
			lfsr_ff <= lfsr_ff[0] ? ((lfsr_ff >> 1) ^ LFSR_TAPS) : (lfsr_ff >> 1);
		end
	end

	assign rand_nib = lfsr_ff[3:0];
	assign c_dmac = cfg[LAG_DMAC] ? clx_fold({20'h0, dmac[11:0]}) : 4'h0;
	assign c_smac = cfg[LAG_SMAC] ? clx_fold({20'h0, smac[11:0]}) : 4'h0;
	assign c_flow = (cfg[LAG_FLOW] && is_ipv6) ? clx_fold({12'h0, flow_label}) : 4'h0;
	assign c_ip4  = (cfg[LAG_IP4] && is_ipv4) ? clx_fold({16'h0, sip[7:0], dip[7:0]}) : 4'h0;
	assign c_l4   = (cfg[LAG_L4] && l4_valid && (is_ipv4 || is_ipv6)) ?
		clx_fold({16'h0, sport[7:0], dport[7:0]}) : 4'h0;
	// random mode ignores every header field
	assign code = cfg[LAG_RAND] ? rand_nib : (c_dmac ^ c_smac ^ c_flow ^ c_ip4 ^ c_l4);

endmodule : clx_lag_code

// >>> clx_pkg.sv
package clx_pkg;

	localparam int NUM_QUEUES = 8;
	localparam int QW         = 3;

	// register byte addresses
	localparam logic [11:0] ADDR_LAG_CFG    = 12'h000;
	localparam logic [11:0] ADDR_QSEL_CFG   = 12'h004;
	localparam logic [11:0] ADDR_RESV_Q_CFG = 12'h008;
	localparam logic [11:0] ADDR_VLAN_CFG   = 12'h00C;
	localparam logic [11:0] ADDR_HDR_PAT    = 12'h010;
	localparam logic [11:0] ADDR_HDR_DC     = 12'h014;
	localparam logic [11:0] ADDR_STATUS     = 12'h018;
	localparam logic [11:0] ADDR_LAST       = 12'h01C;
	localparam logic [3:0]  PORT_REGION     = 4'h1;
	localparam logic [1:0]  PW_TYPE         = 2'h0;
	localparam logic [1:0]  PW_BRIDGE       = 2'h1;
	localparam logic [1:0]  PW_GARP         = 2'h2;
	localparam logic [1:0]  PW_CCM          = 2'h3;

	// lag_code_contrib_cfg bits
	localparam int LAG_DMAC = 0;
	localparam int LAG_SMAC = 1;
	localparam int LAG_FLOW = 2;
	localparam int LAG_IP4  = 3;
	localparam int LAG_L4   = 4;
	localparam int LAG_RAND = 5;

	// cpu_forward_type_cfg bits
	localparam int TYP_IGMP    = 0;
	localparam int TYP_MLD     = 1;
	localparam int TYP_IPMC    = 2;
	localparam int TYP_SRCPORT = 3;
	localparam int TYP_REGACC  = 4;
	localparam int TYP_DROP    = 5;
	localparam int TYP_ALLBR   = 8;

	// cpu_queue_select_cfg_b fields
	localparam int QS_REGACC  = 0;
	localparam int QS_IGMP    = 3;
	localparam int QS_MLD     = 6;
	localparam int QS_IPMC    = 9;
	localparam int QS_SRCPORT = 12;
	// reserved-address queue fields
	localparam int QR_BRIDGE = 0;
	localparam int QR_GARP   = 3;
	localparam int QR_CCM    = 6;

	// reg_access_vlan_cfg fields
	localparam int VL_VID   = 0;
	localparam int VL_AWARE = 12;

	localparam logic [31:0] LAG_CFG_RST  = 32'h0000_0000;
	localparam logic [31:0] QSEL_RST     = 32'h0000_0000;
	localparam logic [31:0] RESV_Q_RST   = 32'h0000_0000;
	localparam logic [31:0] VLAN_RST     = 32'h0000_0000;
	localparam logic [31:0] HDR_PAT_RST  = 32'h0000_0000;
	localparam logic [31:0] HDR_DC_RST   = 32'hFFFF_FFFF;
	localparam logic [31:0] TYPE_RST     = 32'h0000_0020;
	localparam logic [31:0] ADDR_CFG_RST = 32'h0000_0000;

	localparam logic [39:0] BRIDGE_PREFIX  = 40'h01_80C2_0000;
	localparam logic [24:0] IP4_MC_PREFIX  = 25'h020_0BC;
	localparam logic [15:0] IP6_MC_PREFIX  = 16'h3333;
	localparam logic [7:0]  IGMP_PROTO     = 8'h02;
	localparam logic [7:0]  HBH_NEXT_HDR   = 8'h00;
	localparam logic [7:0]  RA_OPT_TYPE    = 8'h05;
	localparam logic [7:0]  RA_OPT_LEN     = 8'h02;
	localparam logic [15:0] RA_OPT_DATA    = 16'h0000;
	localparam logic [23:0] IP4_LOCAL_NET  = 24'hE0_0000;
	localparam logic [15:0] REGACC_ETYPE   = 16'h8880;
	localparam logic [15:0] REGACC_PID     = 16'h0004;
	localparam logic [15:0] LFSR_SEED      = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS      = 16'hB400;

	typedef enum logic [1:0] {
		ACT_NORMAL   = 2'b00,
		ACT_REDIRECT = 2'b01,
		ACT_COPY     = 2'b10,
		ACT_DISCARD  = 2'b11
	} clx_action_type;

	function automatic logic [3:0] clx_fold(input logic [31:0] v);
		logic [3:0] acc;
		acc = 4'h0;
		for (int i = 0; i < 8; i++) begin
			acc = acc ^ v[4*i +: 4];
		end
		return acc;
	endfunction : clx_fold

endpackage : clx_pkg

// >>> clx_resv_lookup.sv
`timescale 1ns/1ps
module clx_resv_lookup
	import clx_pkg::*;
(
	input  wire logic [47:0]    dmac,
	input  wire logic [31:0]    bridge_cfg,
	input  wire logic [1:0]     allbr_cfg,
	input  wire logic [31:0]    garp_cfg,
	input  wire logic [31:0]    ccm_cfg,
	input  wire logic [31:0]    resv_q_cfg,
	output clx_action_type      action,
	output logic      [QW-1:0]  queue
);
	logic [3:0] idx;

	assign idx = dmac[3:0];

	always_comb begin
		action = ACT_NORMAL;
		queue  = resv_q_cfg[QR_BRIDGE +: QW];
		if (dmac[47:8] == BRIDGE_PREFIX) begin
			case (dmac[7:4])
				4'h0: begin
					action = clx_action_type'(bridge_cfg[2*idx +: 2]);
				end
				4'h1: begin
					if (idx == 4'h0) begin
						action = clx_action_type'(allbr_cfg);
					end
				end
				4'h2: begin
					action = clx_action_type'(garp_cfg[2*idx +: 2]);
					queue  = resv_q_cfg[QR_GARP +: QW];
				end
				4'h3: begin
					action = clx_action_type'(ccm_cfg[2*idx +: 2]);
					queue  = resv_q_cfg[QR_CCM +: QW];
				end
				default: begin
					action = ACT_NORMAL;
				end
			endcase
		end
	end

endmodule : clx_resv_lookup

// >>> tb_classifier_aggr_code_cpu_fwd.sv
`timescale 1ns/1ps
module tb_classifier_aggr_code_cpu_fwd
	import clx_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frm_valid = 0;
	logic frm_is_ipv4 = 0, frm_is_ipv6 = 0, frm_l4_valid = 0, frm_mac_ctrl = 0, frm_pause = 0, frm_mac_err = 0;
	logic [11:0] paddr = '0, frm_vid = '0;
	logic [31:0] pwdata = '0, frm_sip = '0, frm_dip = '0, prdata;
	logic [47:0] frm_dmac = '0, frm_smac = '0, frm_payload = '0;
	logic [7:0] frm_ip_proto = '0, frm_opt_type = '0, frm_opt_len = '0, res_cpu_mask, m_cpu;
	logic [15:0] frm_sport = '0, frm_dport = '0, frm_opt_data = '0, frm_etype = '0;
	logic [19:0] frm_flow_label = '0;
	logic [1:0] frm_tag_count = '0;
	logic [9:0] frm_fwd_mask = 10'h3FF, res_fwd_mask, m_fwd;
	logic [7:0] frm_cpu_mask = 8'h01;
	logic [3:0] frm_port = '0, res_lag_code, m_code;
	logic pready, pslverr, res_valid, res_discard, m_disc;
	int fail_count = 0;
	int checks_done = 0;
	clx_classifier #(.NUM_PORTS(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .frm_valid, .frm_port, .frm_dmac, .frm_smac, .frm_is_ipv4, .frm_is_ipv6, .frm_ip_proto,
		.frm_sip, .frm_dip, .frm_flow_label, .frm_l4_valid, .frm_sport, .frm_dport, .frm_opt_type, .frm_opt_len,
		.frm_opt_data, .frm_tag_count, .frm_vid, .frm_etype, .frm_payload, .frm_mac_ctrl, .frm_pause,
		.frm_mac_err, .frm_fwd_mask, .frm_cpu_mask, .res_valid, .res_lag_code, .res_cpu_mask, .res_fwd_mask,
		.res_discard);
	clx_far_model #(.NUM_PORTS(10)) u_far (.pclk, .res_valid, .res_lag_code, .res_cpu_mask, .res_fwd_mask,
		.res_discard, .got_code(m_code), .got_cpu(m_cpu), .got_fwd(m_fwd), .got_disc(m_disc));
	initial forever #25 pclk = ~pclk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang();
		fail_count++;
		$display("BAD %0t no answer", $time);
		report_and_stop();
	endtask : hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 8)
			hang();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	// one frame pulse, then expected cpu mask, forwarding and discard
	task automatic fr(input logic [3:0] p, input logic [7:0] c, input logic [9:0] f, input logic d);
		int i;
		@(posedge pclk);
		frm_port <= p;
		frm_valid <= 1'b1;
		@(posedge pclk);
		frm_valid <= 1'b0;
		for (i = 0; i < 4; i++) begin
			@(posedge pclk);
			if (res_valid === 1'b1)
				break;
		end
		if (i == 4)
			hang();
		@(posedge pclk);
		chk({24'h0, m_cpu}, {24'h0, c});
		chk({22'h0, m_fwd}, {22'h0, f});
		chk({31'h0, m_disc}, {31'h0, d});
	endtask : fr
	function automatic logic [3:0] f4(input logic [31:0] v);
		return v[3:0] ^ v[7:4] ^ v[11:8] ^ v[15:12] ^ v[19:16] ^ v[23:20] ^ v[27:24] ^ v[31:28];
	endfunction : f4
	task automatic sc_reset();
		rd(ADDR_HDR_DC, 32'hFFFF_FFFF, 1'b0);
		rd(12'h100, 32'h0000_0020, 1'b0);
		rd(12'h020, 32'h0000_0000, 1'b1);
		frm_pause <= 1'b1;
		fr(4'h1, 8'h01, 10'h000, 1'b1);
		frm_pause <= 1'b0;
		frm_mac_err <= 1'b1;
		fr(4'h2, 8'h01, 10'h000, 1'b1);
		frm_mac_err <= 1'b0;
	endtask : sc_reset
	task automatic sc_lag();
		wr(ADDR_LAG_CFG, 32'h0000_001F);
		frm_dmac <= 48'h0000_0ABC_D123;
		frm_smac <= 48'h0002_0000_F456;
		frm_is_ipv4 <= 1'b1;
		frm_sip <= 32'h0A00_0078;
		frm_dip <= 32'h0B00_009A;
		frm_l4_valid <= 1'b1;
		frm_sport <= 16'h11BC;
		frm_dport <= 16'h22DE;
		frm_flow_label <= 20'hABCDE;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		chk({28'h0, m_code}, {28'h0, f4(32'h123) ^ f4(32'h456) ^ f4(32'h789A) ^ f4(32'hBCDE)});
		frm_is_ipv4 <= 1'b0;
		frm_is_ipv6 <= 1'b1;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		chk({28'h0, m_code}, {28'h0, f4(32'h123) ^ f4(32'h456) ^ f4(32'hABCDE) ^ f4(32'hBCDE)});
		wr(ADDR_LAG_CFG, 32'h0000_0001);
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		chk({28'h0, m_code}, {28'h0, f4(32'h123)});
		wr(ADDR_LAG_CFG, 32'h0000_003F);
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
	endtask : sc_lag
	task automatic sc_cpu();
		wr(ADDR_QSEL_CFG, 32'h0000_585E);
		wr(12'h100, 32'h0000_0001);
		frm_dmac <= 48'h0100_5E00_0001;
		frm_is_ipv6 <= 1'b0;
		frm_is_ipv4 <= 1'b1;
		frm_ip_proto <= 8'h02;
		fr(4'h0, 8'h09, 10'h000, 1'b0);
		fr(4'h1, 8'h01, 10'h3FF, 1'b0);
		wr(12'h100, 32'h0000_0004);
		frm_ip_proto <= 8'h11;
		frm_dip <= 32'hE000_0005;
		fr(4'h0, 8'h11, 10'h3FF, 1'b0);
		frm_dip <= 32'hE000_0105;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		wr(12'h100, 32'h0000_0002);
		frm_is_ipv4 <= 1'b0;
		frm_is_ipv6 <= 1'b1;
		frm_dmac <= 48'h3333_0000_0001;
		frm_ip_proto <= 8'h00;
		frm_opt_type <= 8'h05;
		frm_opt_len <= 8'h02;
		fr(4'h0, 8'h03, 10'h000, 1'b0);
		frm_opt_len <= 8'h03;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		wr(12'h100, 32'h0000_0008);
		fr(4'h0, 8'h21, 10'h3FF, 1'b0);
	endtask : sc_cpu
	task automatic sc_regacc();
		wr(12'h100, 32'h0000_0010);
		wr(ADDR_HDR_PAT, 32'h1234_5678);
		wr(ADDR_HDR_DC, 32'h0000_00FF);
		frm_dmac <= 48'h0000_0000_0123;
		frm_etype <= 16'h8880;
		frm_payload <= 48'h0004_1234_56AA;
		fr(4'h0, 8'h41, 10'h000, 1'b0);
		frm_payload <= 48'h0004_1334_5678;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		frm_payload <= 48'h0005_1234_5678;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		frm_payload <= 48'h0004_1234_5678;
		frm_tag_count <= 2'h2;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		wr(ADDR_VLAN_CFG, 32'h0000_1064);
		frm_tag_count <= 2'h1;
		frm_vid <= 12'h064;
		fr(4'h0, 8'h41, 10'h000, 1'b0);
		frm_vid <= 12'h065;
		fr(4'h0, 8'h01, 10'h3FF, 1'b0);
		frm_etype <= 16'h0800;
	endtask : sc_regacc
	task automatic sc_resv();
		wr(12'h100, 32'h0000_0200);
		wr(ADDR_RESV_Q_CFG, 32'h0000_013A);
		frm_dmac <= 48'h0180_C200_0010;
		fr(4'h0, 8'h05, 10'h3FF, 1'b0);
		wr(12'h104, 32'h3000_0000);
		frm_dmac <= 48'h0180_C200_000E;
		fr(4'h0, 8'h01, 10'h000, 1'b1);
		wr(12'h104, 32'h1000_0000);
		fr(4'h0, 8'h05, 10'h000, 1'b0);
		wr(12'h108, 32'h0000_0800);
		frm_dmac <= 48'h0180_C200_0025;
		fr(4'h0, 8'h81, 10'h3FF, 1'b0);
		wr(12'h10C, 32'h4000_0000);
		frm_dmac <= 48'h0180_C200_003F;
		fr(4'h0, 8'h11, 10'h000, 1'b0);
		rd(ADDR_STATUS, 32'h0006_0018, 1'b0);
	endtask : sc_resv
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		sc_reset();
		sc_lag();
		sc_cpu();
		sc_regacc();
		sc_resv();
		report_and_stop();
	end
endmodule : tb_classifier_aggr_code_cpu_fwd
